// ==== hdl/mbst_pkg.sv ====
// Package with the constants and types of the memory boundary-scan test port.
package mbst_pkg;

  localparam int BSR_LEN = 71;
  localparam int IR_LEN  = 3;
  localparam int ID_LEN  = 32;

  // Instruction codes.
  localparam logic [2:0] INS_EXT_TEST     = 3'h0;
  localparam logic [2:0] INS_ID_READ      = 3'h1;
  localparam logic [2:0] INS_SAMPLE_FLOAT = 3'h2;
  localparam logic [2:0] INS_RSVD_A       = 3'h3;
  localparam logic [2:0] INS_SAMPLE       = 3'h4;
  localparam logic [2:0] INS_RSVD_B       = 3'h5;
  localparam logic [2:0] INS_RSVD_C       = 3'h6;
  localparam logic [2:0] INS_BYPASS       = 3'h7;

  // Pattern caught in the two low instruction bits on capture.
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  localparam logic       BYPASS_CLEAR   = 1'h0;

  // Identification value; the default is arbitrary.
  localparam logic [31:0] ID_VALUE_DEF = 32'h0A5A5A5B;

  // Consecutive high mode-select edges that always reach the reset state.
  localparam int MS_RESET_EDGES = 5;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } mbst_state_type;

  // Serial link from the board tester after synchronisation.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } mbst_link_type;

  // Instruction decode results.
  typedef struct packed {
    logic sel_bsr;
    logic sel_id;
    logic sel_byp;
    logic float_out;
  } mbst_dec_type;

endpackage

// ==== hdl/mbst_sync.sv ====
// Two-flop synchroniser for the link pins and edge finder for the test clock.
`timescale 1ns/1ps
`default_nettype none
module mbst_sync (
  input  wire logic                   clk_in,     // System clock
  input  wire logic                   rstn_in,    // Async reset, active low
  input  wire mbst_pkg::mbst_link_type pins_in,   // Raw link pins
  output logic                        rise_out,   // Test clock rising edge
  output logic                        fall_out,   // Test clock falling edge
  output mbst_pkg::mbst_link_type     link_out    // Synchronised link
);
  import mbst_pkg::*;

  mbst_link_type meta_q;
  mbst_link_type sync_q;
  logic          tck_last_q;

  // Mode select and data in rest high, as the pull-ups on the balls would hold them; the test clock rests low.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q     <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      sync_q     <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      tck_last_q <= 1'b0;
    end else begin
      meta_q     <= pins_in;
      sync_q     <= meta_q;
      tck_last_q <= sync_q.tck;
    end
  end

  assign rise_out = sync_q.tck & ~tck_last_q;
  assign fall_out = ~sync_q.tck & tck_last_q;
  assign link_out = sync_q;
endmodule
`default_nettype wire

// ==== hdl/mbst_fsm.sv ====
// Sixteen-state test controller sequencer stepped by mode select.
`timescale 1ns/1ps
`default_nettype none
module mbst_fsm (
  input  wire logic                   clk_in,    // System clock
  input  wire logic                   rstn_in,   // Async reset, active low
  input  wire logic                   step_in,   // Test clock rising edge
  input  wire logic                   tms_in,    // Synchronised mode select
  output mbst_pkg::mbst_state_type    state_out  // Current state
);
  import mbst_pkg::*;

  mbst_state_type state_q;
  mbst_state_type state_d;

  always_comb begin
    unique case (state_q)
      ST_RESET:    state_d = tms_in ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_d = tms_in ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_d = tms_in ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_d = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms_in ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms_in ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms_in ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_d = tms_in ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_d = tms_in ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_d = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms_in ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms_in ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms_in ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_d = tms_in ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  // Power-up lands in the reset state.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_RESET;
    end else if (step_in) begin
      state_q <= state_d;
    end
  end

  assign state_out = state_q;
endmodule
`default_nettype wire

// ==== hdl/mbst_tap.sv ====
// Top of the memory boundary-scan test port: instruction, data paths and serial out.
//
// What this block does
// - Seventy-one bit capture chain over memory balls.
// - Capture loads ring values; shift connects chain.
// - Serial in to chain top, out from bottom.
// - Identification instruction captures hardwired 32-bit value.
// - Three-bit instruction, five functional, three reserved.
// - Scan never drives memory; tests only capture.
// - Instruction shifts serially, takes effect at update.
// - All-zero instruction samples and floats outputs.
// - Identification instruction loaded at power-up, reset.
// - Identification register shifts out under its instruction.
// - Capture-and-float connects chain, floats all drivers.
// - Sample snapshots balls without disturbing memory.
// - Update under sample behaves like pause.
// - Bypass puts one bit between in and out.
// - Sample on test clock rise, output on fall.
// - Instruction capture loads low bits with 01.
// - Bypass is one flip-flop cleared on capture.
`timescale 1ns/1ps
`default_nettype none
module mbst_tap #(
  parameter int          BSR_W    = mbst_pkg::BSR_LEN,     // Capture chain length
  parameter logic [31:0] ID_VALUE = mbst_pkg::ID_VALUE_DEF // Arbitrary identification value
) (
  input  wire logic             clk_in,       // System clock, 200 MHz
  input  wire logic             rstn_in,      // Async reset, active low
  input  wire logic             tck_in,       // Test clock pin
  input  wire logic             tms_in,       // Mode select pin
  input  wire logic             tdi_in,       // Serial data in pin
  input  wire logic [BSR_W-1:0] ring_in,      // Memory input and bidirectional ball levels
  output logic                  tdo_out,      // Serial data out
  output logic                  tdo_oen_out,  // Serial out enable, low while driving
  output logic                  mem_float_out // Forces memory output drivers to high impedance
);
  import mbst_pkg::*;

  mbst_link_type  pins;
  mbst_link_type  link;
  logic           tck_rise;
  logic           tck_fall;
  mbst_state_type state;

  logic [BSR_W-1:0]  ring_meta_q;
  logic [BSR_W-1:0]  ring_sync_q;
  logic [BSR_W-1:0]  bsr_q;
  logic [ID_LEN-1:0] id_q;
  logic [IR_LEN-1:0] ir_shift_q;
  logic [IR_LEN-1:0] ir_q;
  logic              byp_q;
  logic              tdo_q;
  logic              tdo_oen_q;
  logic              float_q;

  assign pins = '{tck: tck_in, tms: tms_in, tdi: tdi_in};

  mbst_sync u_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .pins_in  (pins),
    .rise_out (tck_rise),
    .fall_out (tck_fall),
    .link_out (link)
  );

  mbst_fsm u_fsm (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .step_in   (tck_rise),
    .tms_in    (link.tms),
    .state_out (state)
  );

  // Instruction decode; reserved codes fall through to bypass as a safe default.
  function automatic mbst_dec_type decode(input logic [IR_LEN-1:0] code);
    mbst_dec_type d;
    d = '0;
    case (code)
      INS_EXT_TEST: begin
        d.sel_bsr   = 1'b1;
        d.float_out = 1'b1;
      end
      INS_SAMPLE_FLOAT: begin
        d.sel_bsr   = 1'b1;
        d.float_out = 1'b1;
      end
      INS_SAMPLE:  d.sel_bsr = 1'b1;
      INS_ID_READ: d.sel_id  = 1'b1;
      default:     d.sel_byp = 1'b1;
    endcase
    return d;
  endfunction

  mbst_dec_type dec;
  assign dec = decode(ir_q);

  wire in_shift_dr = (state == ST_SHIFT_DR);
  wire in_shift_ir = (state == ST_SHIFT_IR);
  wire in_cap_dr   = (state == ST_CAP_DR);
  wire in_cap_ir   = (state == ST_CAP_IR);
  wire shifting    = in_shift_dr | in_shift_ir;

  wire out_bit = in_shift_ir ? ir_shift_q[0] :
                 dec.sel_bsr ? bsr_q[0] :
                 dec.sel_id  ? id_q[0]  : byp_q;

  // Ball levels come from another clock, so they pass two flops first.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ring_meta_q <= '0;
      ring_sync_q <= '0;
    end else begin
      ring_meta_q <= ring_in;
      ring_sync_q <= ring_meta_q;
    end
  end

  // Boundary chain: capture only, never drives the memory; update acts as pause.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bsr_q <= '0;
    end else if (tck_rise && dec.sel_bsr) begin
      if (in_cap_dr) begin
        bsr_q <= ring_sync_q;
      end else if (in_shift_dr) begin
        bsr_q <= {link.tdi, bsr_q[BSR_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      id_q <= '0;
    end else if (tck_rise && dec.sel_id) begin
      if (in_cap_dr) begin
        id_q <= ID_VALUE;
      end else if (in_shift_dr) begin
        id_q <= {link.tdi, id_q[ID_LEN-1:1]};
      end
    end
  end

  // Single bypass flop, cleared on capture.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      byp_q <= BYPASS_CLEAR;
    end else if (tck_rise && dec.sel_byp) begin
      if (in_cap_dr) begin
        byp_q <= BYPASS_CLEAR;
      end else if (in_shift_dr) begin
        byp_q <= link.tdi;
      end
    end
  end

  // Instruction shifter; the active code only changes at update or in the reset state.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ir_shift_q <= INS_ID_READ;
      ir_q       <= INS_ID_READ;
    end else if (state == ST_RESET) begin
      // Reloaded as soon as the reset state is reached, not a test clock later,
      // so the output float drops within the fifth high mode-select edge.
      ir_q <= INS_ID_READ;
    end else if (tck_rise) begin
      if (in_cap_ir) begin
        ir_shift_q <= {ir_q[IR_LEN-1:2], IR_CAPTURE_LOW};
      end else if (in_shift_ir) begin
        ir_shift_q <= {link.tdi, ir_shift_q[IR_LEN-1:1]};
      end else if (state == ST_UPD_IR) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // Serial out and its enable change on the falling test-clock edge.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tdo_q     <= 1'b0;
      tdo_oen_q <= 1'b1;
    end else if (tck_fall) begin
      tdo_q     <= out_bit;
      tdo_oen_q <= ~shifting;
    end
  end

  // Output float follows the active instruction, also held out of reset.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      float_q <= 1'b0;
    end else begin
      float_q <= dec.float_out;
    end
  end

  assign tdo_out       = tdo_q;
  assign tdo_oen_out   = tdo_oen_q;
  assign mem_float_out = float_q;
endmodule
`default_nettype wire

// ==== verification/mbst_tap_sva.sv ====
// Checker for the serial timing of the boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
module mbst_tap_sva #(
  parameter int          BSR_W    = mbst_pkg::BSR_LEN,
  parameter logic [31:0] ID_VALUE = mbst_pkg::ID_VALUE_DEF
) (
  input wire logic             clk_in,       // Clock
  input wire logic             rstn_in,      // Reset
  input wire logic             tck_in,       // Test clock
  input wire logic             tms_in,       // Mode select
  input wire logic             tdi_in,       // Data in
  input wire logic [BSR_W-1:0] ring_in,      // Balls
  input wire logic             tdo_out,      // Data out
  input wire logic             tdo_oen_out,  // Out enable
  input wire logic             mem_float_out // Float
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic       tck_q;
  logic [2:0] hi_cnt_q;
  logic [2:0] hi_cnt_d;
  // Raw pin rises with mode select high; saturates so a long hold cannot wrap.
  assign hi_cnt_d = !tms_in ? 3'h0 : (hi_cnt_q == 3'h7) ? hi_cnt_q : hi_cnt_q + 3'h1;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tck_q    <= 1'b0;
      hi_cnt_q <= 3'h0;
    end else begin
      tck_q <= tck_in;
      if (tck_in && !tck_q) begin
        hi_cnt_q <= hi_cnt_d;
      end
    end
  end
  tdo_fall_a: assert property ($changed(tdo_out) |-> !tck_in && !$past(tck_in, 2))
    else $error("tdo moved off fall");
  oen_fall_a: assert property ($changed(tdo_oen_out) |-> !$past(tck_in) && !$past(tck_in, 2))
    else $error("enable moved off fall");
  tdo_idle_a: assert property ((!tck_in) [*8] |=> $stable(tdo_out))
    else $error("tdo moved when idle");
  oen_high_a: assert property (tck_in [*3] |=> $stable(tdo_oen_out))
    else $error("enable moved when high");
  float_rise_a: assert property ($changed(mem_float_out) |-> tck_in && $past(tck_in, 2))
    else $error("float moved off update");
  float_quiet_a: assert property ($changed(mem_float_out) |-> tdo_oen_out)
    else $error("float moved in shift");
  float_idle_a: assert property ((!tck_in) [*8] |=> $stable(mem_float_out))
    else $error("float moved when idle");
  reset_path_a: assert property (hi_cnt_q > 3'h4 && !tck_in |->
    tdo_oen_out && !mem_float_out) else $error("mode reset missed");
endmodule
`default_nettype wire

// ==== verification/mbst_tester.sv ====
// Board tester model driving test clock, mode select and serial data in.
`timescale 1ns/1ps
`default_nettype none
module mbst_tester (
  input  wire logic clk_in,  // Clock
  input  wire logic tdo_in,  // Data out
  output var logic  tck_out, // Test clock, still between frames
  output var logic  tms_out, // Mode select
  output var logic  tdi_out  // Data in, pulled high when released
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // One 125 ns period: 13 clocks low, 12 high.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk_in);
    tms_out <= tms;
    tdi_out <= tdi;
    repeat (12) @(posedge clk_in);
    tdo = tdo_in;
    tck_out <= 1'b1;
    repeat (12) @(posedge clk_in);
    tck_out <= 1'b0;
    tdi_out <= 1'b1;
  endtask
  task automatic scan(input logic ir, input int n, input logic [79:0] din,
                      output logic [79:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b1, b);
    if (ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
  // After any reset the sequencer sits in the reset state and needs one low edge.
  task automatic go_idle();
    logic b;
    step(1'b0, 1'b1, b);
  endtask
  task automatic tms_reset();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Testbench of the boundary-scan test port with a board tester model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mbst_pkg::*;
  typedef struct {
    logic [2:0] code;
    logic       flt;
    int         len;
  } mbst_row_type;
  // Ring only changes between frames, so every captured bit, the clock ball too, is settled.
  localparam logic [70:0] RING = 71'h1C3F00F96A55A3C81;
  logic [70:0] ring;
  localparam logic [79:0] DIN  = 80'hB4;
  logic        clk, rstn, tck, tms, tdi, tdo, oen, flt;
  logic [79:0] got;
  int          n_errors;
  int          checks_done;
  mbst_row_type rows [5] = '{'{INS_EXT_TEST, 1'b1, BSR_LEN}, '{INS_ID_READ, 1'b0, ID_LEN},
    '{INS_SAMPLE_FLOAT, 1'b1, BSR_LEN}, '{INS_SAMPLE, 1'b0, BSR_LEN}, '{INS_BYPASS, 1'b0, 1}};
  mbst_tap u_dut (.clk_in(clk), .rstn_in(rstn), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .ring_in(ring), .tdo_out(tdo), .tdo_oen_out(oen), .mem_float_out(flt));
  mbst_tester u_tst (.clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] act);
    checks_done++;
    if (act !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, act);
    end
  endtask
  // One extra byte behind the path shows its length and shift direction.
  task automatic dr_case(input string what, input int len);
    logic [79:0] cap;
    cap = len == BSR_LEN ? 80'(ring) : len == ID_LEN ? 80'(ID_VALUE_DEF) : 80'h0;
    u_tst.scan(1'b0, len + 8, DIN, got);
    check(what, cap | (DIN << len), got);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always #2.5 clk = ~clk;
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ring = RING;
    n_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check("idle outputs", 80'h2, {77'h0, tdo, oen, flt});
    u_tst.go_idle();
    dr_case("power-up path", ID_LEN);
    $display("test power-up done");
    foreach (rows[k]) begin
      u_tst.scan(1'b1, 3, 80'(rows[k].code), got);
      check("ir capture", 80'h1, got & 80'h3);
      check("float", 80'(rows[k].flt), 80'(flt));
      dr_case("path", rows[k].len);
      ring <= ~ring;
      @(posedge clk);
      dr_case("path again", rows[k].len);
      $display("test code %h done", rows[k].code);
    end
    u_tst.scan(1'b1, 3, 80'(INS_EXT_TEST), got);
    u_tst.tms_reset();
    check("float after mode reset", 80'h0, 80'(flt));
    dr_case("path after mode reset", ID_LEN);
    $display("test mode reset done");
    u_tst.scan(1'b1, 3, 80'(INS_SAMPLE_FLOAT), got);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check("outputs in reset", 80'h2, {77'h0, tdo, oen, flt});
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    u_tst.go_idle();
    dr_case("path after reset", ID_LEN);
    $display("test hard reset done");
    end_sim();
  end
endmodule
bind mbst_tap mbst_tap_sva #(.BSR_W(BSR_W), .ID_VALUE(ID_VALUE)) u_sva (.clk_in, .rstn_in,
  .tck_in, .tms_in, .tdi_in, .ring_in, .tdo_out, .tdo_oen_out, .mem_float_out);
`default_nettype wire
